// >>> rtl/usb_desc_defines.svh
// Summary of operation
// - Language string: 04h length, 03h type
// - No config or no strings: stall index zero
// - Language code read from bytes 0x23-0x24
// - Indices 1-5 stall when string absent
// - String bytes sent raw from memory
// - Requested language identifier is ignored
// - Companion descriptor fixed: 06h, 30h, zeros
// - Burst byte from bulk-in burst limit
// - Burst byte holds packets minus one, 0-15
`ifndef USB_DESC_DEFINES_SVH
`define USB_DESC_DEFINES_SVH

// ---------------------------------------------------------------------------
// Descriptor constants
// ---------------------------------------------------------------------------
`define LANG_DESC_LEN    8'h04
`define STRING_DESC_TYPE 8'h03
`define LANG_CODE_ADDR   9'h023
`define LANG_BASE_ADDR   9'h021
`define COMP_DESC_LEN    8'h06
`define COMP_DESC_TYPE   8'h30
`define COMP_ATTR        8'h00
`define COMP_BPI_BYTE    8'h00
`define BURST_RESET      4'h3
`define NUM_STRINGS      5
`define STR_INDEX_MAX    8'h05

`endif

// >>> rtl/usb_desc_pkg.sv
package usb_desc_pkg;

   // ------------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------------
   // Responder sequencer states
   typedef enum logic [2:0]
   {
      S_IDLE  = 3'b000,
      S_FETCH = 3'b001,
      S_WAIT  = 3'b010,
      S_LOAD  = 3'b011,
      S_SEND  = 3'b100
   } state_type;

   // Kind of descriptor asked for
   typedef enum logic [1:0]
   {
      REQ_STRING    = 2'b00,
      REQ_COMPANION = 2'b01
   } req_kind_type;

   // Kind of descriptor being sent
   typedef enum logic [1:0]
   {
      K_LANG = 2'b00,
      K_STR  = 2'b01,
      K_COMP = 2'b10
   } desc_kind_type;

endpackage

// >>> rtl/string_dir_if.sv
`timescale 1ns/1ns

// Carries one string directory lookup between the sequencer and the table
interface string_dir_if #(parameter int AW = 9);
   logic [7:0]    index;       // Requested string index
   logic [7:0]    str_len;     // Stored byte count of selected string
   logic [AW-1:0] str_off;     // Stored memory offset of selected string
   logic          str_exists;  // Selected index names a stored string
   logic          any_string;  // At least one stored length is nonzero

   modport table_side
   (
      input  index,
      output str_len,
      output str_off,
      output str_exists,
      output any_string
   );
   modport seq_side
   (
      output index,
      input  str_len,
      input  str_off,
      input  str_exists,
      input  any_string
   );
endinterface

// >>> rtl/string_dir.sv
`timescale 1ns/1ns
`include "usb_desc_defines.svh"

module string_dir #(
   parameter int AW = 9
) (
   input  wire logic [8*`NUM_STRINGS-1:0]  i_str_len_flat,
   input  wire logic [AW*`NUM_STRINGS-1:0] i_str_off_flat,
   string_dir_if.table_side                dir
);

   // ------------------------------------------------------------------------
   // Per-entry decode
   // ------------------------------------------------------------------------
   logic [`NUM_STRINGS-1:0] len_nz;     // Entry length nonzero
   logic [`NUM_STRINGS-1:0] hit;        // Entry selected by index
   logic [7:0]              len_or   [`NUM_STRINGS:0];
   logic [AW-1:0]           off_or   [`NUM_STRINGS:0];

   assign len_or[0] = 8'h00;
   assign off_or[0] = '0;

   // Indices 1..5 map onto entries 0..4; other indices hit nothing
   for (genvar g = 0; g < `NUM_STRINGS; g++)
   begin : g_entry
      assign len_nz[g]  = |i_str_len_flat[8*g +: 8];
      assign hit[g]     = (dir.index == 8'(g + 1));
      assign len_or[g+1] = len_or[g] | (hit[g] ? i_str_len_flat[8*g +: 8] : 8'h00);
      assign off_or[g+1] = off_or[g] | (hit[g] ? i_str_off_flat[AW*g +: AW] : '0);
   end

   // ------------------------------------------------------------------------
   // Lookup results
   // ------------------------------------------------------------------------
   assign dir.str_len    = len_or[`NUM_STRINGS];
   assign dir.str_off    = off_or[`NUM_STRINGS];
   assign dir.str_exists = |(hit & len_nz);
   assign dir.any_string = |len_nz;

endmodule

// >>> rtl/usb_desc_responder.sv
`timescale 1ns/1ns
`include "usb_desc_defines.svh"

module usb_desc_responder #(
   parameter int AW = 9
) (
   input  wire logic                       i_sys_clk,
   input  wire logic                       i_reset_n,
   input  wire logic                       i_req_valid,
   input  wire logic [1:0]                 i_req_kind,
   input  wire logic [7:0]                 i_req_index,
   input  wire logic [15:0]                i_req_langid,
   input  wire logic [15:0]                i_req_max_len,
   input  wire logic                       i_cfg_valid,
   input  wire logic [8*`NUM_STRINGS-1:0]  i_str_len_flat,
   input  wire logic [AW*`NUM_STRINGS-1:0] i_str_off_flat,
   input  wire logic [3:0]                 i_bulk_in_burst_limit,
   input  wire logic [7:0]                 i_mem_data,
   input  wire logic                       i_byte_ready,
   output logic                            o_req_ready,
   output logic [AW-1:0]                   o_mem_addr,
   output logic                            o_mem_rd,
   output logic [7:0]                      o_byte,
   output logic                            o_byte_valid,
   output logic                            o_byte_last,
   output logic                            o_stall,
   output logic                            o_done
);

   // ------------------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------------------
   usb_desc_pkg::state_type     state_r;     // Sequencer state
   usb_desc_pkg::state_type     state_nxt;   // Next sequencer state
   usb_desc_pkg::desc_kind_type kind_r;      // Descriptor being sent
   logic [7:0]                  cnt_r;       // Current byte index
   logic [7:0]                  total_r;     // Bytes to send
   logic [AW-1:0]               base_r;      // Memory base of byte zero

   string_dir_if #(.AW(AW))     dir ();      // String table lookup

   // Request decode
   wire        req_take    = i_req_valid & o_req_ready;
   wire        is_string   = (i_req_kind == usb_desc_pkg::REQ_STRING);
   wire        is_comp     = (i_req_kind == usb_desc_pkg::REQ_COMPANION);
   wire        idx_zero    = (i_req_index == 8'h00);
   wire        lang_ok     = i_cfg_valid & dir.any_string;
   wire        str_ok      = i_cfg_valid & dir.str_exists;
   wire        want_lang   = req_take & is_string & idx_zero & lang_ok;
   wire        want_str    = req_take & is_string & !idx_zero & str_ok;
   wire        want_comp   = req_take & is_comp;
   wire        want_stall  = req_take & !(want_lang | want_str | want_comp);
   // Language field ignored: string choice rests on index only
   wire        langid_unused = ^i_req_langid;

   // Length chosen per kind, cut to the host's requested length
   wire [7:0]  full_len    = want_lang ? `LANG_DESC_LEN :
                             want_str  ? dir.str_len    : `COMP_DESC_LEN;
   wire        len_cut     = (i_req_max_len < {8'h00, full_len});
   wire [7:0]  start_len   = len_cut ? i_req_max_len[7:0] : full_len;
   wire        go_send     = (want_lang | want_str | want_comp) & (start_len != 8'h00);

   // Byte source selection
   wire        from_mem    = (kind_r == usb_desc_pkg::K_STR) |
                             ((kind_r == usb_desc_pkg::K_LANG) & (cnt_r >= 8'h02));
   wire [AW-1:0] byte_addr = base_r + AW'(cnt_r);
   wire [7:0]  lang_const  = (cnt_r == 8'h00) ? `LANG_DESC_LEN : `STRING_DESC_TYPE;
   wire [7:0]  comp_const  = (cnt_r == 8'h00) ? `COMP_DESC_LEN  :
                             (cnt_r == 8'h01) ? `COMP_DESC_TYPE :
                             (cnt_r == 8'h02) ? {4'h0, i_bulk_in_burst_limit} :
                             (cnt_r == 8'h03) ? `COMP_ATTR      : `COMP_BPI_BYTE;
   wire [7:0]  byte_val    = from_mem ? i_mem_data :
                             (kind_r == usb_desc_pkg::K_COMP) ? comp_const : lang_const;
   wire        is_last     = (cnt_r == total_r - 8'h01);
   wire        byte_taken  = (state_r == usb_desc_pkg::S_SEND) & i_byte_ready;

   // ------------------------------------------------------------------------
   // String table
   // ------------------------------------------------------------------------
   assign dir.index = i_req_index;

   string_dir #(.AW(AW)) u_dir
   (
      .i_str_len_flat (i_str_len_flat),
      .i_str_off_flat (i_str_off_flat),
      .dir            (dir)
   );

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         usb_desc_pkg::S_IDLE:
         begin
            // Only non-empty answers start a byte sequence
            if (go_send)
            begin
               state_nxt = usb_desc_pkg::S_FETCH;
            end
         end
         usb_desc_pkg::S_FETCH: state_nxt = usb_desc_pkg::S_WAIT;
         usb_desc_pkg::S_WAIT:  state_nxt = usb_desc_pkg::S_LOAD;
         usb_desc_pkg::S_LOAD:  state_nxt = usb_desc_pkg::S_SEND;
         usb_desc_pkg::S_SEND:
         begin
            // Hold the byte until the host side takes it
            if (i_byte_ready)
            begin
               state_nxt = is_last ? usb_desc_pkg::S_IDLE : usb_desc_pkg::S_FETCH;
            end
         end
         default: state_nxt = usb_desc_pkg::S_IDLE;
      endcase
   end

   // ------------------------------------------------------------------------
   // Sequencer registers
   // ------------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_r <= usb_desc_pkg::S_IDLE;
         kind_r  <= usb_desc_pkg::K_LANG;
         cnt_r   <= 8'h00;
         total_r <= 8'h00;
         base_r  <= '0;
      end
      else
      begin
         state_r <= state_nxt;
         if (req_take)
         begin
            // Language code sits two bytes past the base
            kind_r  <= want_lang ? usb_desc_pkg::K_LANG :
                       want_str  ? usb_desc_pkg::K_STR  : usb_desc_pkg::K_COMP;
            base_r  <= want_lang ? AW'(`LANG_BASE_ADDR) : dir.str_off;
            total_r <= start_len;
            cnt_r   <= 8'h00;
         end
         else if (byte_taken)
         begin
            cnt_r <= cnt_r + 8'h01;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Memory read port
   // ------------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_mem_addr <= '0;
         o_mem_rd   <= 1'b0;
      end
      else
      begin
         o_mem_addr <= byte_addr;
         o_mem_rd   <= (state_r == usb_desc_pkg::S_FETCH) & from_mem;
      end
   end

   // ------------------------------------------------------------------------
   // Byte output
   // ------------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_byte       <= 8'h00;
         o_byte_valid <= 1'b0;
         o_byte_last  <= 1'b0;
      end
      else if (state_r == usb_desc_pkg::S_LOAD)
      begin
         // Memory bytes pass unchanged; fixed bytes from constants
         o_byte       <= byte_val;
         o_byte_valid <= 1'b1;
         o_byte_last  <= is_last;
      end
      else if (byte_taken)
      begin
         o_byte_valid <= 1'b0;
         o_byte_last  <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------------------
   always_ff @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_req_ready <= 1'b1;
         o_stall     <= 1'b0;
         o_done      <= 1'b0;
      end
      else
      begin
         o_req_ready <= (state_nxt == usb_desc_pkg::S_IDLE) & !req_take;
         o_stall     <= want_stall;
         o_done      <= (byte_taken & is_last) | (req_take & !want_stall & !go_send)
                        | (langid_unused & 1'b0);
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   lang_header_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_r == usb_desc_pkg::S_LOAD && kind_r == usb_desc_pkg::K_LANG && cnt_r < 8'h02)
      |=> o_byte == ((cnt_r == 8'h01) ? 8'h03 : 8'h04))
      else $error("language header byte wrong");

   lang_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (req_take && is_string && idx_zero && !(i_cfg_valid && dir.any_string))
      |=> o_stall && !o_byte_valid)
      else $error("language request not stalled");

   lang_code_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_r == usb_desc_pkg::S_FETCH && kind_r == usb_desc_pkg::K_LANG && cnt_r == 8'h02)
      |=> o_mem_rd && o_mem_addr == 9'h023)
      else $error("language code not read at its address");

   str_stall_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (req_take && is_string && !idx_zero && i_req_index <= 8'h05
       && !(i_cfg_valid && dir.str_exists))
      |=> o_stall ##1 o_req_ready)
      else $error("absent string not stalled");

   str_raw_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_r == usb_desc_pkg::S_LOAD && kind_r == usb_desc_pkg::K_STR)
      |=> o_byte_valid && o_byte == $past(i_mem_data))
      else $error("string byte altered");

   langid_free_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (req_take && is_string && !idx_zero && i_cfg_valid && dir.str_exists)
      |=> !o_stall)
      else $error("existing string stalled");

   comp_fixed_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_r == usb_desc_pkg::S_LOAD && kind_r == usb_desc_pkg::K_COMP && cnt_r != 8'h02)
      |=> o_byte == ((cnt_r == 8'h00) ? 8'h06 : (cnt_r == 8'h01) ? 8'h30 : 8'h00))
      else $error("companion fixed byte wrong");

   burst_byte_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (state_r == usb_desc_pkg::S_LOAD && kind_r == usb_desc_pkg::K_COMP && cnt_r == 8'h02)
      |=> o_byte[3:0] == $past(i_bulk_in_burst_limit))
      else $error("burst byte not from burst limit");

   burst_range_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_byte_valid && kind_r == usb_desc_pkg::K_COMP && cnt_r == 8'h02)
      |-> o_byte <= 8'h0f)
      else $error("burst byte out of range");

   high_index_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (req_take && is_string && i_req_index > 8'h05) |=> o_stall)
      else $error("high string index not stalled");

   byte_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
      (o_byte_valid && !i_byte_ready) |=> o_byte_valid && $stable(o_byte))
      else $error("byte dropped before taken");

endmodule

// >>> tb/host_sink.sv
`timescale 1ns/1ns

// ---------------------------------------------------------------------------
// Host side of the data stage
// ---------------------------------------------------------------------------
// Takes descriptor bytes at full rate, or with random stalls when slow
module host_sink (
   input  wire logic i_sys_clk,    // System clock
   input  wire logic i_reset_n,    // Async reset, active low
   input  wire logic i_slow,       // Stall at random when high
   output logic      o_byte_ready  // Host accepts the offered byte
);
   // Readiness drawn anew each edge
   always @(posedge i_sys_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_byte_ready <= 1'b0;
      else
         o_byte_ready <= !i_slow || ($urandom % 3 == 0);
   end
endmodule

// >>> tb/usb_string_companion_desc_tb.sv
`timescale 1ns/1ns

module usb_string_companion_desc_tb;
   // ------------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------------
   logic        i_sys_clk = 0;       // 10 MHz clock
   logic        i_reset_n = 0;       // Reset, active low
   logic        req_valid = 0;       // Request strobe
   logic [1:0]  req_kind = 0;        // Descriptor kind
   logic [7:0]  req_index = 0;       // String index
   logic [15:0] req_langid = 0;      // Requested language
   logic [15:0] req_max_len = 0;     // Host length limit
   logic        cfg_valid = 0;       // Config memory present
   logic [39:0] lens = 0;            // String lengths
   logic [44:0] offs = 0;            // String offsets
   logic [3:0]  burst = 0;           // Burst limit field
   logic [7:0]  mem_data = 0;        // Memory read data
   logic        slow = 0;            // Host stalls at random
   logic        byte_ready;          // Host readiness
   logic        req_ready;           // Request accepted when high
   logic [8:0]  mem_addr;            // Memory address
   logic        mem_rd;              // Memory strobe
   logic [7:0]  o_byte;              // Descriptor byte
   logic        byte_valid;          // Byte offered
   logic        byte_last;           // Final byte
   logic        stall;               // Stall pulse
   logic        done;                // Done pulse
   logic [7:0]  mem [512];           // Configuration image
   logic [9:0]  q [$];               // Expected notes: kind and byte
   int          n_mismatch = 0;      // Mismatches seen
   int          samples_checked = 0; // Comparisons made

   always #50 i_sys_clk = ~i_sys_clk;

   usb_desc_responder u_usb_desc_responder (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_req_valid(req_valid),
      .i_req_kind(req_kind), .i_req_index(req_index), .i_req_langid(req_langid),
      .i_req_max_len(req_max_len), .i_cfg_valid(cfg_valid), .i_str_len_flat(lens),
      .i_str_off_flat(offs), .i_bulk_in_burst_limit(burst), .i_mem_data(mem_data),
      .i_byte_ready(byte_ready), .o_req_ready(req_ready), .o_mem_addr(mem_addr),
      .o_mem_rd(mem_rd), .o_byte(o_byte), .o_byte_valid(byte_valid),
      .o_byte_last(byte_last), .o_stall(stall), .o_done(done));

   host_sink u_host_sink (
      .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_slow(slow),
      .o_byte_ready(byte_ready));

   // ------------------------------------------------------------------------
   // Memory: data valid one cycle after the strobe, scrambled otherwise
   // ------------------------------------------------------------------------
   always @(posedge i_sys_clk)
   begin
      if (mem_rd)
         mem_data <= mem[mem_addr];
      else
         mem_data <= ~mem_data;
   end

   // ------------------------------------------------------------------------
   // Checking
   // ------------------------------------------------------------------------
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Oldest note, unknown when none is due
   function automatic logic [9:0] nxt();
      nxt = 10'bx;
      if (q.size() != 0)
         nxt = q.pop_front();
   endfunction

   // Watcher of the answer side
   always @(posedge i_sys_clk)
   begin
      if (i_reset_n && byte_valid && byte_ready)
         check({1'b0, byte_last, o_byte}, nxt());
      if (i_reset_n && stall)
         check(10'h200, nxt());
      if (i_reset_n && done)
         check(10'h300, nxt());
   end

   task automatic results();
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------------------
   // Request driver: notes the answer, then asks
   // ------------------------------------------------------------------------
   task automatic send(input logic [1:0] k, input logic [7:0] idx, input logic [15:0] ml);
      logic [7:0] b [$];
      logic [7:0] ln;
      logic [8:0] off;
      int         n;
      bit         stl;
      stl = (k != 2'h1) && (k != 2'h0 || idx > 8'h05);
      if (k == 2'h1)
         b = '{8'h06, 8'h30, {4'h0, burst}, 8'h00, 8'h00, 8'h00};
      else if (!stl && idx == 8'h00)
      begin
         stl = !cfg_valid || lens == 40'h0;
         b = '{8'h04, 8'h03, mem[9'h023], mem[9'h024]};
      end
      else if (!stl)
      begin
         ln = lens[8*(idx-1)+:8];
         off = offs[9*(idx-1)+:9];
         stl = !cfg_valid || ln == 8'h00;
         for (int i = 0; i < ln; i++)
            b.push_back(mem[off+i]);
      end
      n = (b.size() < ml) ? b.size() : ml;
      if (stl)
         q.push_back(10'h200);
      else
      begin
         for (int i = 0; i < n; i++)
            q.push_back({1'b0, i == n - 1, b[i]});
         q.push_back(10'h300);
      end
      @(posedge i_sys_clk);
      req_valid <= 1'b1;
      req_kind <= k;
      req_index <= idx;
      req_langid <= 16'($urandom);
      req_max_len <= ml;
      @(posedge i_sys_clk);
      check({9'h000, req_ready}, 10'h001);
      req_valid <= 1'b0;
      for (int i = 0; i < 300 && q.size() != 0; i++)
         @(negedge i_sys_clk);
      // Notes still waiting mean an answer never came
      if (q.size() != 0)
      begin
         n_mismatch++;
         q.delete();
      end
   endtask

   // New configuration, applied at an edge
   task automatic setup(input logic c, input logic [39:0] l);
      @(posedge i_sys_clk);
      cfg_valid <= c;
      lens <= l;
      // Let the new values settle before notes are made from them
      @(posedge i_sys_clk);
   endtask

   // ------------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------------
   initial
   begin
      void'($urandom(66739));
      for (int i = 0; i < 512; i++)
         mem[i] = 8'($urandom);
      mem[9'h023] = 8'h09;
      mem[9'h024] = 8'h04;
      // Strings of 1..5 characters, string four left out
      for (int k = 1; k <= 5; k++)
      begin
         offs[9*(k-1)+:9] = 9'h040 + 9'(32 * k);
         mem[9'h040 + 9'(32 * k)] = 8'(2 + 2 * k);
         mem[9'h041 + 9'(32 * k)] = 8'h03;
      end
      repeat (20) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      setup(1'b0, 40'h0c_00_08_06_04);
      send(2'h0, 8'h00, 16'h40);
      send(2'h0, 8'h03, 16'h40);
      setup(1'b1, 40'h0);
      send(2'h0, 8'h00, 16'h40);
      send(2'h0, 8'h01, 16'h40);
      setup(1'b1, 40'h0c_00_08_06_04);
      for (int s = 0; s < 2; s++)
      begin
         slow <= s[0];
         for (int i = 0; i < 8; i++)
            send(2'h0, 8'(i), 16'h40);
      end
      send(2'h0, 8'hff, 16'h40);
      send(2'h2, 8'h01, 16'h40);
      send(2'h3, 8'h01, 16'h40);
      send(2'h0, 8'h05, 16'h0);
      send(2'h0, 8'h05, 16'h3);
      send(2'h0, 8'h00, 16'h2);
      for (int i = 0; i < 16; i++)
      begin
         @(posedge i_sys_clk);
         burst <= 4'(i);
         // Burst value must stand before the note is made
         @(posedge i_sys_clk);
         send(2'h1, 8'(i), 16'h40);
      end
      results();
   end

   // Watchdog, well beyond the expected run
   initial
   begin
      repeat (20000) @(posedge i_sys_clk);
      n_mismatch++;
      results();
   end
endmodule
